/* File: design/ibus_cfg.svh */
// Constants for the interleaved PCM backplane bus control block
`ifndef IBUS_CFG_SVH
`define IBUS_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define IBUS_CTRL_ADDR 8'h94
`define IBUS_CTRL_RESET 4'h0
`define IBUS_BIT_ENABLE 3
`define IBUS_BIT_TYPE 2
`define IBUS_BIT_MASTER_SELECT_BIT0 1
`define IBUS_BIT_MASTER_SELECT_BIT1 0

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define IBUS_SLOTS_TWO 2'h1
`define IBUS_SLOTS_FOUR 2'h3
`define IBUS_FRAME_LAST 5'h1F
`define IBUS_IDLE_BYTE 8'hFF
`define IBUS_FIFO_DEPTH 16
`define IBUS_DATA_W 8

`endif

/* File: design/ibus_fifo.sv */
// Byte FIFO between the framer receive side and the shared bus
`timescale 1ns/1ps
module ibus_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Flush
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) wr_d = wr_q + 1'b1;
            if (pop) rd_d = rd_q + 1'b1;
            if (push && !pop) cnt_d = cnt_q + 1'b1;
            if (pop && !push) cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock) begin
        if (push && !flush) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : ibus_fifo

/* File: design/ibus_pkg.sv */
// Types for the interleaved PCM backplane bus control block
package ibus_pkg;
    typedef enum logic [1:0] {
        ROLE_OFF,
        ROLE_SLAVE,
        ROLE_MASTER_TWO,
        ROLE_MASTER_FOUR
    } role_t;
endpackage : ibus_pkg

/* File: design/interleaved_pcm_backplane_bus.sv */
// Per-framer interleaved PCM backplane bus control
`timescale 1ns/1ps
`include "ibus_cfg.svh"
module interleaved_pcm_backplane_bus (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Parallel control port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Receive byte stream from the elastic store
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    // Slot position of this framer when slave
    input wire logic [1:0] slave_position,
    // Shared bus timing
    input wire logic bus_byte_tick,
    input wire logic receive_sync_pin,
    output logic bus_sync_out,
    // Shared bus data, byte output with one shared active-low output enable
    output logic [7:0] bus_data_out,
    output logic bus_data_oe_n,
    // Status
    output logic bus_active
);
    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [3:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;

    function automatic ibus_pkg::role_t decode_role(input logic [3:0] c);
        if (!c[`IBUS_BIT_ENABLE]) return ibus_pkg::ROLE_OFF;
        case ({c[`IBUS_BIT_MASTER_SELECT_BIT1], c[`IBUS_BIT_MASTER_SELECT_BIT0]})
            2'h0: return ibus_pkg::ROLE_SLAVE;
            2'h1: return ibus_pkg::ROLE_MASTER_TWO;
            2'h2: return ibus_pkg::ROLE_MASTER_FOUR;
            default: return ibus_pkg::ROLE_OFF;
        endcase
    endfunction : decode_role

    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        if (wr_en && addr == `IBUS_CTRL_ADDR) begin
            ctrl_d = wdata[3:0];
        end
        if (rd_en) begin
            rdata_d = (addr == `IBUS_CTRL_ADDR) ? {4'h0, ctrl_q} : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= `IBUS_CTRL_RESET;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // ----------------------------------------
    // Buffer from elastic store to bus
    // ----------------------------------------
    ibus_pkg::role_t role;
    logic fifo_valid, fifo_pop;
    logic [7:0] fifo_data;
    logic participating;

    assign role = decode_role(ctrl_q);
    assign participating = (role != ibus_pkg::ROLE_OFF);

    ibus_fifo #(
        .WIDTH(`IBUS_DATA_W),
        .DEPTH(`IBUS_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data),
        .flush(!participating)
    );

    // ----------------------------------------
    // Slot sequencer
    // ----------------------------------------
    logic [1:0] slot_q, slot_d, my_slot, last_slot;
    logic [4:0] byte_q, byte_d;
    logic cur_is_mine, sync_d, sync_q, oe_n_d, oe_n_q;
    logic [7:0] bus_d, bus_q;
    logic frame_mode, group_start;

    assign frame_mode = ctrl_q[`IBUS_BIT_TYPE];

    always_comb begin
        my_slot = 2'h0;
        last_slot = `IBUS_SLOTS_FOUR;
        case (role)
            ibus_pkg::ROLE_MASTER_TWO: last_slot = `IBUS_SLOTS_TWO;
            ibus_pkg::ROLE_MASTER_FOUR: last_slot = `IBUS_SLOTS_FOUR;
            ibus_pkg::ROLE_SLAVE: my_slot = slave_position;
            default: my_slot = 2'h0;
        endcase
    end

    always_comb begin
        slot_d = slot_q;
        byte_d = byte_q;
        sync_d = 1'b0;
        group_start = 1'b0;
        if (!participating) begin
            slot_d = 2'h0;
            byte_d = 5'h00;
        end else if (bus_byte_tick) begin
            if (role == ibus_pkg::ROLE_SLAVE && receive_sync_pin) begin
                group_start = 1'b1;
            end else if (role != ibus_pkg::ROLE_SLAVE) begin
                group_start = (slot_q == 2'h0) && (byte_q == 5'h00);
            end
            if (group_start) begin
                slot_d = 2'h0;
                byte_d = 5'h00;
            end
            // Advance to the slot of the next tick
            if (frame_mode) begin
                if (byte_d == `IBUS_FRAME_LAST) begin
                    byte_d = 5'h00;
                    slot_d = (slot_d == last_slot) ? 2'h0 : slot_d + 2'h1;
                end else begin
                    byte_d = byte_d + 5'h01;
                end
            end else begin
                slot_d = (slot_d == last_slot) ? 2'h0 : slot_d + 2'h1;
            end
            sync_d = group_start && (role != ibus_pkg::ROLE_SLAVE);
        end
    end

    assign cur_is_mine = participating && bus_byte_tick
        && ((group_start ? 2'h0 : slot_q) == my_slot);
    assign fifo_pop = cur_is_mine && fifo_valid;

    always_comb begin
        bus_d = bus_q;
        oe_n_d = oe_n_q;
        if (!participating) begin
            oe_n_d = 1'b1;
        end else if (bus_byte_tick) begin
            oe_n_d = !cur_is_mine;
            bus_d = fifo_valid ? fifo_data : `IBUS_IDLE_BYTE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            slot_q <= 2'h0;
            byte_q <= 5'h00;
            sync_q <= 1'b0;
            bus_q <= `IBUS_IDLE_BYTE;
            oe_n_q <= 1'b1;
        end else begin
            slot_q <= slot_d;
            byte_q <= byte_d;
            sync_q <= sync_d;
            bus_q <= bus_d;
            oe_n_q <= oe_n_d;
        end
    end

    logic active_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            active_q <= 1'b0;
        end else begin
            active_q <= participating;
        end
    end

    assign bus_sync_out = sync_q;
    assign bus_data_out = bus_q;
    assign bus_data_oe_n = oe_n_q;
    assign bus_active = active_q;
endmodule : interleaved_pcm_backplane_bus

/* File: tb/bp_model.sv */
// Backplane model: byte ticks, slave sync and capture of driven bytes
`timescale 1ns/1ps
module bp_model (
    // Clock and control
    input wire logic clock,
    input wire logic run,
    // Timing toward the framer
    output logic bus_byte_tick = 1'b0,
    output logic receive_sync_pin = 1'b0,
    // Shared bus
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe_n
);
    logic [7:0] got[$];
    logic [1:0] phase = 2'h0;
    logic [1:0] slot = 2'h0;
    logic tick_seen = 1'b0;
    always @(posedge clock) begin
        tick_seen <= bus_byte_tick;
        if (tick_seen && !bus_data_oe_n)
            got.push_back(bus_data_out);
        phase <= run ? phase + 2'h1 : 2'h0;
        bus_byte_tick <= run && phase == 2'h0;
        receive_sync_pin <= run && phase == 2'h0 && slot == 2'h0;
        if (!run)
            slot <= 2'h0;
        else if (phase == 2'h0)
            slot <= slot + 2'h1;
    end
endmodule : bp_model

/* File: tb/ibus_chk.sv */
// Checker of the interleaved bus control block
`timescale 1ns/1ps
module ibus_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    // Stream and bus
    input wire logic rx_ready,
    input wire logic bus_byte_tick,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe_n,
    input wire logic bus_active
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> bus_data_oe_n && !bus_active) else $error("live in reset");
    a_enable_on: assert property (wr_en && addr == 8'h94 && wdata[3]
        && wdata[1:0] != 2'h3 |-> ##[1:2] bus_active) else $error("not active");
    a_enable_off: assert property (wr_en && addr == 8'h94 && !wdata[3]
        |-> ##[1:2] !bus_active) else $error("still active");
    a_drive_tick: assert property ($fell(bus_data_oe_n) |-> $past(bus_byte_tick))
        else $error("drive off tick");
    a_data_hold: assert property (!bus_data_oe_n && !$past(bus_byte_tick)
        |-> $stable(bus_data_out)) else $error("byte moved");
    a_rd_unmapped: assert property (rd_en && addr != 8'h94 |=> rdata == 8'h00)
        else $error("unmapped read");
    a_rd_upper: assert property (rd_en |=> rdata[7:4] == 4'h0)
        else $error("upper bits");
    a_rdata_hold: assert property (!rd_en |=> $stable(rdata))
        else $error("rdata moved");
    c_drive: cover property (bus_byte_tick ##1 !bus_data_oe_n);
    c_full: cover property (!rx_ready);
    c_read: cover property (rd_en ##1 rdata != 8'h00);
endmodule : ibus_chk
bind interleaved_pcm_backplane_bus ibus_chk chk (.clock, .rst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .rx_ready, .bus_byte_tick, .bus_data_out, .bus_data_oe_n, .bus_active);

/* File: tb/testbench.sv */
// Bench for the interleaved PCM backplane bus control block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rx_data = 8'h00;
    logic wr_en = 1'b0, rd_en = 1'b0, rx_valid = 1'b0, run = 1'b0;
    logic [1:0] slave_position = 2'h2;
    logic [7:0] rdata, bus_data_out;
    logic rx_ready, bus_byte_tick, receive_sync_pin, bus_sync_out, bus_data_oe_n, bus_active;
    int fails = 0, tests_run = 0, cycles = 0, syncs = 0;
    interleaved_pcm_backplane_bus dut (.clock, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .rx_valid, .rx_ready, .rx_data, .slave_position, .bus_byte_tick, .receive_sync_pin,
        .bus_sync_out, .bus_data_out, .bus_data_oe_n, .bus_active);
    bp_model bp (.clock, .run, .bus_byte_tick, .receive_sync_pin, .bus_data_out,
        .bus_data_oe_n);
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
    endtask : wr
    task automatic cfg(input logic [7:0] d);
        wr(8'h94, 8'h00);
        wr(8'h94, d);
    endtask : cfg
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(negedge clock);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        check("rdata", rdata, want);
    endtask : rd
    task automatic push_n(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_data = 8'h40 + 8'(i);
        end
        @(negedge clock);
        rx_valid = 1'b0;
    endtask : push_n
    task automatic ticks(input int n);
        @(negedge clock);
        run = 1'b1;
        repeat (4 * n) @(negedge clock);
        run = 1'b0;
        repeat (6) @(negedge clock);
    endtask : ticks
    task automatic expect_bus(input int n, input int full);
        check("drives", 8'(bp.got.size()), 8'(n));
        for (int i = 0; i < n && i < bp.got.size(); i++)
            check("byte", bp.got[i], i < full ? 8'h40 + 8'(i) : 8'hFF);
        bp.got.delete();
    endtask : expect_bus
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    always @(posedge clock) begin
        cycles++;
        if (bus_sync_out === 1'b1)
            syncs++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check("idle", {6'h00, bus_data_oe_n, bus_active}, 8'h02);
        wr(8'h94, 8'hFA);
        rd(8'h94, 8'h0A);
        wr(8'h93, 8'h05);
        rd(8'h94, 8'h0A);
        rd(8'h93, 8'h00);
        for (int v = 0; v < 16; v++) begin
            wr(8'h94, 8'(v));
            @(negedge clock);
            check("active", {7'h00, bus_active}, {7'h00, v[3] && v[1:0] != 2'h3});
        end
        cfg(8'h0A);
        push_n(17);
        check("ready", {7'h00, rx_ready}, 8'h00);
        ticks(40);
        expect_bus(20, 16);
        check("ready", {7'h00, rx_ready}, 8'h01);
        cfg(8'h0E);
        ticks(64);
        expect_bus(32, 0);
        cfg(8'h09);
        syncs = 0;
        ticks(8);
        expect_bus(2, 0);
        check("syncs", 8'(syncs), 8'h02);
        cfg(8'h08);
        syncs = 0;
        ticks(8);
        expect_bus(2, 0);
        check("syncs", 8'(syncs), 8'h00);
        cfg(8'h0B);
        ticks(4);
        expect_bus(0, 0);
        cfg(8'h06);
        push_n(3);
        ticks(4);
        expect_bus(0, 0);
        wr(8'h94, 8'h0A);
        ticks(4);
        expect_bus(2, 0);
        end_of_test();
    end
endmodule : testbench
